// ### common/gnss_timing_defines.vh
`ifndef GNSS_TIMING_DEFINES_VH
`define GNSS_TIMING_DEFINES_VH
// ==========================================================
// protocol select codes
`define PROTO_NMEA 3'h0
`define PROTO_BIN1 3'h1
`define PROTO_TIMING 3'h2
`define PROTO_ASCII 3'h3
// ==========================================================
// binary framing bytes and field positions
`define BIN_DLE 8'h10
`define BIN_ETX 8'h03
`define BIN_PKT_ID 8'hA1
`define BIN_SUB_ID 8'h00
`define BIN_IDX_ID 6'h01
`define BIN_IDX_SUB 6'h02
`define BIN_IDX_HOUR 6'h0C
`define BIN_IDX_MIN 6'h0D
`define BIN_IDX_SEC 6'h0E
`define BIN_IDX_MON 6'h0F
`define BIN_IDX_DAY 6'h10
`define BIN_IDX_YRH 6'h11
`define BIN_IDX_YRL 6'h12
`define BIN_IDX_OFFH 6'h16
`define BIN_IDX_OFFL 6'h17
`define BIN_IDX_CHK 6'h24
`define BIN_IDX_END 6'h25
// ==========================================================
// ascii sentence characters and field numbers
`define CH_START 8'h24
`define CH_COMMA 8'h2C
`define CH_STAR 8'h2A
`define TYPE_NONE 2'h0
`define TYPE_TL 2'h1
`define TYPE_ANT 2'h2
`define TYPE_JAM 2'h3
`define F_TL_DT 4'h2
`define F_TL_STAT 4'h3
`define F_TL_PLS 4'h5
`define F_TL_FLS 4'h6
`define F_ANT_RX 4'hA
`define F_JAM_TYPE 4'h2
`define F_JAM_LINES 4'h3
`define F_JAM_FREQ 4'h5
`define F_JAM_PEAK 4'h6
`define TSTAT_LS_FIX 2'h2
// ==========================================================
// leap window: constellation offset to tai and guard seconds
`define GPS_TO_TAI 16'h0013
`define LEAP_GUARD 6'h04
`endif

// ### src/gnss_timing_message_parser.v
// Function
// - binary packet starts with 0x10, ends with 0x10 then 0x03
// - read signed 16-bit utc offset from the binary timing report
// - 3-bit protocol field: 0 nmea, 1 binary, 2 timing, 3 ascii
// - each ascii sentence type ignored when its disable bit is set
// - use binary report offset so local time runs on tai
// - use time-leap sentence offset to correct utc to tai
// - suppress adjustments 4s around leap midnight until offset updates
// - candidate leap instants are ends of 30 june and 31 december
// - tolerate repeated 59 or 58 to 0 without time jump
// - in ascii mode also accept standard nmea sentences
// - recognise start char, P, maker code, then sentence type
// - fields split on commas, asterisk ends last field
// - two hex characters after asterisk form the checksum
// - decode fourteen-digit date-time field of time-leap sentence
// - time status: 0 no fix, 1 leap unknown, 2 leap fixed
// - take present and future leap counts, ignore update and pps
// - receiver state bits 3:0 give antenna current state
// - receiver state bits 7:4 give spoofing indication
// - other antenna sentence fields are ignored
// - use jam type, line count, first jammer frequency and peak
`timescale 1ns/1ns
`include "gnss_timing_defines.vh"
module gnss_timing_message_parser
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // received bytes
  input wire [7:0] rx_byte,
  input wire rx_valid,
  // configuration
  input wire [2:0] protocol_sel,
  input wire disable_time_leap_sentence,
  input wire disable_antenna_sentence,
  input wire disable_jamming_sentence,
  // time of day
  output reg time_update_q,
  output reg [15:0] year_q,
  output reg [7:0] month_q,
  output reg [7:0] day_q,
  output reg [7:0] hour_q,
  output reg [7:0] minute_q,
  output reg [7:0] second_q,
  output reg [15:0] tai_offset_q,
  output reg adjust_inhibit_q,
  // leap and status
  output reg [1:0] time_status_q,
  output reg [7:0] present_leap_count_q,
  output reg [7:0] future_leap_count_q,
  output reg [3:0] antenna_state_q,
  output reg spoof_detect_q,
  output reg jam_glonass_q,
  output reg [7:0] total_output_lines_q,
  output reg [15:0] first_jammer_frequency_q,
  output reg [15:0] first_jammer_peak_q,
  // events and errors
  output reg nmea_sentence_q,
  output reg checksum_error_q,
  output reg protocol_illegal_q
);

  // ========================================================
  // helpers
  function [15:0] dec_push;
    input [15:0] val;
    input [7:0] ch;
    begin
      dec_push = (val << 3) + (val << 1) + {12'h000, ch[3:0]};
    end
  endfunction

  function [7:0] dec8;
    input [7:0] val;
    input [7:0] ch;
    begin
      dec8 = (val << 3) + (val << 1) + {4'h0, ch[3:0]};
    end
  endfunction

  localparam [23:0] maker_id = 24'h585956; // arbitrary value

  function [4:0] hex_val;
    input [7:0] ch;
    begin
      if (ch >= 8'h30 && ch <= 8'h39)
        hex_val = {1'b1, ch[3:0]};
      else if (ch >= 8'h41 && ch <= 8'h46)
        hex_val = {1'b1, ch[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  function leap_window;
    input [7:0] mo;
    input [7:0] dy;
    input [7:0] hr;
    input [7:0] mi;
    input [7:0] se;
    begin
      leap_window = (((mo == 8'h06 && dy == 8'h1E) ||
                      (mo == 8'h0C && dy == 8'h1F)) &&
                     hr == 8'h17 && mi == 8'h3B &&
                     se >= 8'h3C - {2'b00, `LEAP_GUARD}) ||
                    (((mo == 8'h07) || (mo == 8'h01)) && dy == 8'h01 &&
                     hr == 8'h00 && mi == 8'h00 &&
                     se <= {2'b00, `LEAP_GUARD});
    end
  endfunction

  // ========================================================
  // binary framing
  reg bin_active_q;
  reg bin_esc_q;
  reg [5:0] bin_idx_q;
  reg [7:0] bin_sum_q;
  reg [7:0] bin_chk_q;
  reg bin_hdr_q;
  reg [7:0] b_hour_q, b_min_q, b_sec_q, b_mon_q, b_day_q;
  reg [15:0] b_year_q, b_off_q;
  wire sel_bin = rx_valid && (protocol_sel == `PROTO_TIMING);
  wire is_dle = (rx_byte == `BIN_DLE);
  // doubled 0x10 is data, 0x10 0x03 closes the packet
  wire bin_take = sel_bin && bin_active_q &&
                  (bin_esc_q ? is_dle : !is_dle);
  wire bin_close = sel_bin && bin_active_q && bin_esc_q &&
                   (rx_byte == `BIN_ETX);
  wire bin_commit = bin_close && bin_hdr_q &&
                    (bin_idx_q == `BIN_IDX_END) &&
                    (bin_sum_q == bin_chk_q);

  // binary frame tracking
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bin_active_q <= 1'b0;
      bin_esc_q <= 1'b0;
      bin_idx_q <= 6'h00;
      bin_sum_q <= 8'h00;
    end
    else if (sel_bin)
    begin
      if (!bin_active_q)
      begin
        bin_active_q <= is_dle;
        bin_esc_q <= 1'b0;
        bin_idx_q <= 6'h01;
        bin_sum_q <= 8'h00;
      end
      else if (bin_take)
      begin
        bin_esc_q <= 1'b0;
        bin_idx_q <= (bin_idx_q == 6'h3F) ? bin_idx_q : bin_idx_q + 6'h01;
        if (bin_idx_q < `BIN_IDX_CHK)
          bin_sum_q <= bin_sum_q + rx_byte;
      end
      else if (!bin_esc_q)
        bin_esc_q <= 1'b1;
      else
        bin_active_q <= 1'b0; // close or broken escape
    end
  end

  // binary field capture, big endian
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bin_hdr_q <= 1'b0;
      bin_chk_q <= 8'h00;
      b_hour_q <= 8'h00;
      b_min_q <= 8'h00;
      b_sec_q <= 8'h00;
      b_mon_q <= 8'h00;
      b_day_q <= 8'h00;
      b_year_q <= 16'h0000;
      b_off_q <= 16'h0000;
    end
    else if (bin_take)
    begin
      if (bin_idx_q == `BIN_IDX_ID)
        bin_hdr_q <= (rx_byte == `BIN_PKT_ID);
      if (bin_idx_q == `BIN_IDX_SUB && rx_byte != `BIN_SUB_ID)
        bin_hdr_q <= 1'b0;
      if (bin_idx_q == `BIN_IDX_HOUR) b_hour_q <= rx_byte;
      if (bin_idx_q == `BIN_IDX_MIN) b_min_q <= rx_byte;
      if (bin_idx_q == `BIN_IDX_SEC) b_sec_q <= rx_byte;
      if (bin_idx_q == `BIN_IDX_MON) b_mon_q <= rx_byte;
      if (bin_idx_q == `BIN_IDX_DAY) b_day_q <= rx_byte;
      if (bin_idx_q == `BIN_IDX_YRH) b_year_q[15:8] <= rx_byte;
      if (bin_idx_q == `BIN_IDX_YRL) b_year_q[7:0] <= rx_byte;
      // signed 16-bit offset, constellation time minus utc
      if (bin_idx_q == `BIN_IDX_OFFH) b_off_q[15:8] <= rx_byte;
      if (bin_idx_q == `BIN_IDX_OFFL) b_off_q[7:0] <= rx_byte;
      if (bin_idx_q == `BIN_IDX_CHK) bin_chk_q <= rx_byte;
    end
  end

  // ========================================================
  // ascii sentence scanning
  reg a_active_q;
  reg [3:0] a_field_q;
  reg [4:0] a_pos_q;
  reg [7:0] a_xor_q;
  reg [1:0] a_type_q;
  reg a_hdr_q;
  reg a_nmea_q;
  reg a_ck_q;
  reg [3:0] a_ck_hi_q;
  reg a_neg_q;
  reg [15:0] a_acc_q;
  reg [15:0] s_year_q;
  reg [7:0] s_mon_q, s_day_q, s_hour_q, s_min_q, s_sec_q;
  reg [1:0] s_stat_q;
  reg [7:0] s_pls_q, s_fls_q, s_rx_q, s_lines_q;
  reg s_glo_q;
  reg [15:0] s_freq_q, s_peak_q;
  wire sel_asc = rx_valid && (protocol_sel == `PROTO_ASCII);
  wire is_digit = (rx_byte >= 8'h30) && (rx_byte <= 8'h39);
  wire [4:0] hex_nib = hex_val(rx_byte);
  wire [15:0] acc_pos = dec_push(a_acc_q, rx_byte);
  wire [7:0] acc_sgn = a_neg_q ? 8'h00 - a_acc_q[7:0] : a_acc_q[7:0];
  wire field_end = sel_asc && a_active_q && !a_ck_q &&
                   (rx_byte == `CH_COMMA || rx_byte == `CH_STAR);
  // second hex character completes the checksum
  wire ck_done = sel_asc && a_active_q && a_ck_q && a_pos_q[0] &&
                 hex_nib[4];
  wire ck_good = ck_done && ({a_ck_hi_q, hex_nib[3:0]} == a_xor_q);
  wire type_off = (a_type_q == `TYPE_TL && disable_time_leap_sentence) ||
                  (a_type_q == `TYPE_ANT && disable_antenna_sentence) ||
                  (a_type_q == `TYPE_JAM && disable_jamming_sentence);
  // unknown maker or type never commits
  wire asc_commit = ck_good && a_hdr_q && (a_type_q != `TYPE_NONE) &&
                    !type_off;
  wire tl_commit = asc_commit && (a_type_q == `TYPE_TL);

  // sentence framing and checksum
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      a_active_q <= 1'b0;
      a_field_q <= 4'h0;
      a_pos_q <= 5'h00;
      a_xor_q <= 8'h00;
      a_type_q <= `TYPE_NONE;
      a_hdr_q <= 1'b0;
      a_nmea_q <= 1'b0;
      a_ck_q <= 1'b0;
      a_ck_hi_q <= 4'h0;
    end
    else if (sel_asc)
    begin
      if (rx_byte == `CH_START)
      begin
        a_active_q <= 1'b1;
        a_field_q <= 4'h0;
        a_pos_q <= 5'h00;
        a_xor_q <= 8'h00;
        a_type_q <= `TYPE_NONE;
        a_hdr_q <= 1'b1;
        a_nmea_q <= 1'b0;
        a_ck_q <= 1'b0;
      end
      else if (a_active_q && a_ck_q)
      begin
        // two hex digits, bad digit drops
        a_ck_hi_q <= hex_nib[3:0];
        a_pos_q <= a_pos_q + 5'h01;
        if (!hex_nib[4] || a_pos_q[0])
          a_active_q <= 1'b0;
      end
      else if (a_active_q)
      begin
        // comma splits fields, asterisk ends the last
        if (rx_byte == `CH_STAR)
        begin
          a_ck_q <= 1'b1;
          a_pos_q <= 5'h00;
        end
        else
        begin
          a_xor_q <= a_xor_q ^ rx_byte;
          if (rx_byte == `CH_COMMA)
          begin
            a_field_q <= (a_field_q == 4'hF) ? a_field_q : a_field_q + 4'h1;
            a_pos_q <= 5'h00;
          end
          else
            a_pos_q <= (a_pos_q == 5'h1F) ? a_pos_q : a_pos_q + 5'h01;
        end
        // proprietary id, maker code, then sentence type
        if (a_field_q == 4'h0)
        begin
          if (a_pos_q == 5'h00 && rx_byte == 8'h47)
            a_nmea_q <= 1'b1;
          if ((a_pos_q == 5'h00 && rx_byte != 8'h50) ||
              (a_pos_q == 5'h01 && rx_byte != maker_id[23:16]) ||
              (a_pos_q == 5'h02 && rx_byte != maker_id[15:8]) ||
              (a_pos_q == 5'h03 && rx_byte != maker_id[7:0]) ||
              (a_pos_q == 5'h04 && rx_byte != 8'h43) ||
              (a_pos_q == 5'h05 && rx_byte != 8'h52) ||
              (a_pos_q == 5'h07 && rx_byte != `CH_COMMA))
            a_hdr_q <= 1'b0;
          if (a_pos_q == 5'h06)
            a_type_q <= (rx_byte == 8'h57) ? `TYPE_TL :
                        (rx_byte == 8'h59) ? `TYPE_ANT :
                        (rx_byte == 8'h4A) ? `TYPE_JAM : `TYPE_NONE;
        end
      end
    end
  end

  // field values into shadow registers
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      a_acc_q <= 16'h0000;
      a_neg_q <= 1'b0;
      s_year_q <= 16'h0000;
      s_mon_q <= 8'h00;
      s_day_q <= 8'h00;
      s_hour_q <= 8'h00;
      s_min_q <= 8'h00;
      s_sec_q <= 8'h00;
      s_stat_q <= 2'h0;
      s_pls_q <= 8'h00;
      s_fls_q <= 8'h00;
      s_rx_q <= 8'h00;
      s_lines_q <= 8'h00;
      s_glo_q <= 1'b0;
      s_freq_q <= 16'h0000;
      s_peak_q <= 16'h0000;
    end
    else if (field_end || (sel_asc && rx_byte == `CH_START))
    begin
      a_acc_q <= 16'h0000;
      a_neg_q <= 1'b0;
      if (field_end && a_type_q == `TYPE_TL)
      begin
        if (a_field_q == `F_TL_STAT) s_stat_q <= a_acc_q[1:0];
        if (a_field_q == `F_TL_PLS) s_pls_q <= acc_sgn;
        if (a_field_q == `F_TL_FLS) s_fls_q <= acc_sgn;
      end
      // state word, other antenna fields skipped
      if (field_end && a_type_q == `TYPE_ANT && a_field_q == `F_ANT_RX)
        s_rx_q <= a_acc_q[7:0];
      if (field_end && a_type_q == `TYPE_JAM)
      begin
        // lines, first jammer frequency and peak only
        if (a_field_q == `F_JAM_LINES) s_lines_q <= a_acc_q[7:0];
        if (a_field_q == `F_JAM_FREQ) s_freq_q <= a_acc_q;
        if (a_field_q == `F_JAM_PEAK) s_peak_q <= a_acc_q;
      end
    end
    else if (sel_asc && a_active_q && !a_ck_q)
    begin
      if (rx_byte == 8'h2D)
        a_neg_q <= 1'b1;
      else if (is_digit)
        a_acc_q <= acc_pos;
      // jam type letter: second char L means glonass
      if (a_type_q == `TYPE_JAM && a_field_q == `F_JAM_TYPE &&
          a_pos_q == 5'h01)
        s_glo_q <= (rx_byte == 8'h4C);
      if (a_type_q == `TYPE_TL && a_field_q == `F_TL_DT && is_digit)
      begin
        if (a_pos_q < 5'h04) s_year_q <= dec_push(s_year_q, rx_byte);
        else if (a_pos_q < 5'h06)
          s_mon_q <= dec8(s_mon_q, rx_byte);
        else if (a_pos_q < 5'h08)
          s_day_q <= dec8(s_day_q, rx_byte);
        else if (a_pos_q < 5'h0A)
          s_hour_q <= dec8(s_hour_q, rx_byte);
        else if (a_pos_q < 5'h0C)
          s_min_q <= dec8(s_min_q, rx_byte);
        else if (a_pos_q < 5'h0E)
          s_sec_q <= dec8(s_sec_q, rx_byte);
      end
      if (a_type_q == `TYPE_TL && a_field_q == `F_TL_DT && a_pos_q == 5'h00)
      begin
        s_year_q <= {12'h000, rx_byte[3:0]};
        s_mon_q <= 8'h00;
        s_day_q <= 8'h00;
        s_hour_q <= 8'h00;
        s_min_q <= 8'h00;
        s_sec_q <= 8'h00;
      end
    end
  end

  // ========================================================
  // common time commit and leap window
  reg win_q;
  reg [15:0] win_off_q;
  wire tm_load = bin_commit || tl_commit;
  wire [7:0] n_mon = bin_commit ? b_mon_q : s_mon_q;
  wire [7:0] n_day = bin_commit ? b_day_q : s_day_q;
  wire [7:0] n_hour = bin_commit ? b_hour_q : s_hour_q;
  wire [7:0] n_min = bin_commit ? b_min_q : s_min_q;
  wire [7:0] n_sec = bin_commit ? b_sec_q : s_sec_q;
  // tai offset is field plus gps-to-tai
  wire off_load = bin_commit || (tl_commit && s_stat_q == `TSTAT_LS_FIX);
  wire [15:0] n_off = (bin_commit ? b_off_q : {{8{s_pls_q[7]}}, s_pls_q}) +
                      `GPS_TO_TAI;
  wire [15:0] off_now = off_load ? n_off : tai_offset_q;
  wire n_win = leap_window(n_mon, n_day, n_hour, n_min, n_sec);

  // time of day, offset and adjustment inhibit
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      time_update_q <= 1'b0;
      year_q <= 16'h0000;
      month_q <= 8'h00;
      day_q <= 8'h00;
      hour_q <= 8'h00;
      minute_q <= 8'h00;
      second_q <= 8'h00;
      tai_offset_q <= 16'h0000;
      adjust_inhibit_q <= 1'b0;
      win_q <= 1'b0;
      win_off_q <= 16'h0000;
    end
    else
    begin
      time_update_q <= tm_load;
      if (off_load)
        tai_offset_q <= n_off;
      if (tm_load)
      begin
        year_q <= bin_commit ? b_year_q : s_year_q;
        month_q <= n_mon;
        day_q <= n_day;
        hour_q <= n_hour;
        minute_q <= n_min;
        second_q <= n_sec;
        win_q <= n_win;
        if (n_win && !win_q)
          win_off_q <= tai_offset_q;
        // hold in window until offset changes
        adjust_inhibit_q <= n_win &&
                            (!win_q || off_now == win_off_q);
      end
    end
  end

  // status from time-leap, antenna and jamming sentences
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      time_status_q <= 2'h0;
      present_leap_count_q <= 8'h00;
      future_leap_count_q <= 8'h00;
      antenna_state_q <= 4'h0;
      spoof_detect_q <= 1'b0;
      jam_glonass_q <= 1'b0;
      total_output_lines_q <= 8'h00;
      first_jammer_frequency_q <= 16'h0000;
      first_jammer_peak_q <= 16'h0000;
      nmea_sentence_q <= 1'b0;
      checksum_error_q <= 1'b0;
      protocol_illegal_q <= 1'b0;
    end
    else
    begin
      // codes above the ascii protocol are illegal
      protocol_illegal_q <= (protocol_sel > `PROTO_ASCII);
      checksum_error_q <= (ck_done && !ck_good) ||
                          (bin_close && bin_hdr_q && !bin_commit);
      nmea_sentence_q <= ck_good && a_nmea_q;
      if (tl_commit)
      begin
        time_status_q <= s_stat_q;
        present_leap_count_q <= s_pls_q;
        future_leap_count_q <= s_fls_q;
      end
      if (asc_commit && a_type_q == `TYPE_ANT)
      begin
        antenna_state_q <= s_rx_q[3:0];
        spoof_detect_q <= (s_rx_q[7:4] != 4'h0);
      end
      if (asc_commit && a_type_q == `TYPE_JAM)
      begin
        jam_glonass_q <= s_glo_q;
        total_output_lines_q <= s_lines_q;
        first_jammer_frequency_q <= s_freq_q;
        first_jammer_peak_q <= s_peak_q;
      end
    end
  end

endmodule

// ### sim/gnss_timing_message_parser_sva.sv
`timescale 1ns/1ns
// ==========================================
// checker on the parser ports
module gnss_timing_message_parser_sva
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // configuration
  input wire [2:0] protocol_sel,
  input wire disable_time_leap_sentence,
  // observed outputs
  input wire time_update_q,
  input wire [7:0] month_q,
  input wire [7:0] day_q,
  input wire [7:0] hour_q,
  input wire [7:0] minute_q,
  input wire [7:0] second_q,
  input wire [15:0] tai_offset_q,
  input wire adjust_inhibit_q,
  input wire nmea_sentence_q,
  input wire checksum_error_q,
  input wire protocol_illegal_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_illegal_flag: assert property ((protocol_sel > 3'h3) [*3]
    |-> protocol_illegal_q) else $error("no illegal flag");
  a_legal_clear: assert property ((protocol_sel <= 3'h3) [*3]
    |-> !protocol_illegal_q) else $error("false illegal");
  a_update_mode: assert property ((protocol_sel != 3'h2 &&
    protocol_sel != 3'h3) [*3] |-> !time_update_q)
    else $error("mode commit");
  a_nmea_mode: assert property ((protocol_sel != 3'h3) [*3]
    |-> !nmea_sentence_q) else $error("mode sentence");
  a_bad_sum_hold: assert property (checksum_error_q
    |-> !time_update_q && $stable(tai_offset_q))
    else $error("bad sum stored");
  a_update_pulse: assert property (time_update_q |=> !time_update_q)
    else $error("long pulse");
  a_leap_date: assert property ($rose(adjust_inhibit_q) |->
    (month_q == 8'h06 && day_q == 8'h1E) ||
    (month_q == 8'h0C && day_q == 8'h1F) ||
    ((month_q == 8'h07 || month_q == 8'h01) && day_q == 8'h01))
    else $error("hold date");
  a_leap_time: assert property ($rose(adjust_inhibit_q) |->
    (hour_q == 8'h17 && minute_q == 8'h3B && second_q >= 8'h38) ||
    (hour_q == 8'h00 && minute_q == 8'h00 && second_q <= 8'h04))
    else $error("hold time");
  a_inhibit_hold: assert property (adjust_inhibit_q &&
    !time_update_q ##1 !time_update_q |-> adjust_inhibit_q)
    else $error("hold dropped");
  a_tl_disabled: assert property ((protocol_sel == 3'h3 &&
    disable_time_leap_sentence) [*3] |-> !time_update_q)
    else $error("disabled commit");
  // main scenarios
  c_binary: cover property (time_update_q && protocol_sel == 3'h2);
  c_leap: cover property ($rose(adjust_inhibit_q));
  c_bad_sum: cover property (checksum_error_q);
endmodule
bind gnss_timing_message_parser gnss_timing_message_parser_sva chk
(
  .core_clk, .rst, .protocol_sel, .disable_time_leap_sentence,
  .time_update_q, .month_q, .day_q, .hour_q, .minute_q, .second_q,
  .tai_offset_q, .adjust_inhibit_q, .nmea_sentence_q, .checksum_error_q,
  .protocol_illegal_q
);

// ### sim/gnss_receiver_model.sv
`timescale 1ns/1ns
// ==========================================
// receiver model driving the byte stream
module gnss_receiver_model
(
  // clock
  input wire core_clk,
  // byte stream
  output reg [7:0] rx_byte,
  output reg rx_valid
);
  // idle line at time zero
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  // one byte, inverse once released
  task put(input [7:0] b);
  begin
    @(negedge core_clk);
    rx_byte = b;
    rx_valid = 1'b1;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
  end
  endtask
  task send_report(input [7:0] h, mi, s, mo, d, input [15:0] y, off,
    input bad);
    reg [7:0] pk [1:36];
    integer i;
  begin
    for (i = 1; i <= 36; i = i + 1)
      pk[i] = 8'h00;
    pk[1] = 8'hA1;
    pk[4] = 8'h20;
    pk[5] = 8'h02;
    pk[12] = h;
    pk[13] = mi;
    pk[14] = s;
    pk[15] = mo;
    pk[16] = d;
    {pk[17], pk[18]} = y;
    pk[21] = 8'h03;
    {pk[22], pk[23]} = off;
    for (i = 1; i <= 35; i = i + 1)
      pk[36] = pk[36] + pk[i];
    pk[36] = pk[36] ^ {7'h00, bad};
    put(8'h10);
    for (i = 1; i <= 36; i = i + 1)
    begin
      put(pk[i]);
      if (pk[i] == 8'h10)
        put(8'h10);
    end
    put(8'h10);
    put(8'h03);
    repeat (4) @(negedge core_clk);
  end
  endtask
  task send_text(input string s, input bad);
    reg [7:0] x;
    integer i;
  begin
    x = {7'h00, bad};
    put(8'h24);
    for (i = 0; i < s.len(); i = i + 1)
    begin
      x = x ^ s[i];
      put(s[i]);
    end
    put(8'h2A);
    put(hex(x[7:4]));
    put(hex(x[3:0]));
    repeat (4) @(negedge core_clk);
  end
  endtask
  // nibble to hex digit
  function [7:0] hex(input [3:0] n);
    hex = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
endmodule

// ### sim/gnss_timing_message_parser_tb_top.sv
`timescale 1ns/1ns
// ==========================================
// bench for the timing message parser
module gnss_timing_message_parser_tb_top;
  localparam [23:0] good_maker = 24'h585956; // arbitrary
  localparam [23:0] other_maker = 24'h515251; // arbitrary
  reg core_clk, rst, dis_tl, dis_ant, dis_jam;
  reg [2:0] protocol_sel;
  wire [7:0] rx_byte, month_q, day_q, hour_q, minute_q, second_q;
  wire [7:0] present_leap_count_q, future_leap_count_q, total_output_lines_q;
  wire [15:0] year_q, tai_offset_q, first_jammer_frequency_q;
  wire [15:0] first_jammer_peak_q;
  wire [3:0] antenna_state_q;
  wire [1:0] time_status_q;
  wire rx_valid, time_update_q, adjust_inhibit_q, spoof_detect_q;
  wire jam_glonass_q, nmea_sentence_q, checksum_error_q, protocol_illegal_q;
  integer err_count = 0, total_checks = 0, cyc = 0;
  integer upd_n = 0, nmea_n = 0, cerr_n = 0;
  // ==========================================
  // design and receiver
  gnss_timing_message_parser dut
  (
    .core_clk, .rst, .rx_byte, .rx_valid, .protocol_sel,
    .disable_time_leap_sentence(dis_tl), .disable_antenna_sentence(dis_ant),
    .disable_jamming_sentence(dis_jam), .time_update_q, .year_q, .month_q,
    .day_q, .hour_q, .minute_q, .second_q, .tai_offset_q, .adjust_inhibit_q,
    .time_status_q, .present_leap_count_q, .future_leap_count_q,
    .antenna_state_q, .spoof_detect_q, .jam_glonass_q, .total_output_lines_q,
    .first_jammer_frequency_q, .first_jammer_peak_q, .nmea_sentence_q,
    .checksum_error_q, .protocol_illegal_q
  );
  gnss_receiver_model rx (.core_clk, .rx_byte, .rx_valid);
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // event counters and run limit
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (time_update_q === 1'b1) upd_n <= upd_n + 1;
    if (nmea_sentence_q === 1'b1) nmea_n <= nmea_n + 1;
    if (checksum_error_q === 1'b1) cerr_n <= cerr_n + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  // compare one value
  task ck(input string what, input [31:0] seen, exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  // proprietary sentence
  task prop(input [23:0] m, input [7:0] t, input string b, input bad);
  begin
    rx.send_text($sformatf("P%c%c%cCR%c%s", m[23:16], m[15:8], m[7:0],
      t, b), bad);
  end
  endtask
  // time-leap sentence with status 2
  task tl(input string dt, pl);
  begin
    prop(good_maker, 8'h57, {",TPS1,", dt, ",2,1,", pl, ",+19,0"}, 1'b0);
  end
  endtask
  // binary report, then a bad sum
  task t_binary;
  begin
    protocol_sel = 3'h2;
    rx.send_report(8'h0C, 8'h10, 8'h1E, 8'h03, 8'h0F, 16'h07E9, 16'h0012,
      1'b0);
    ck("update", upd_n, 32'h1);
    ck("minute", minute_q, 32'h10);
    ck("hour", hour_q, 32'h0C);
    ck("year", year_q, 32'h07E9);
    ck("offset", tai_offset_q, 32'h25);
    rx.send_report(8'h0D, 8'h00, 8'h00, 8'h03, 8'h0F, 16'h07E9, 16'h0014,
      1'b1);
    ck("sum_err", cerr_n, 32'h1);
    ck("no_update", upd_n, 32'h1);
    ck("offset_kept", tai_offset_q, 32'h25);
    $display("binary test done");
  end
  endtask
  // time-leap sentences around a june leap
  task t_leap;
  begin
    protocol_sel = 3'h3;
    tl("20250530235958", "+18");
    ck("no_hold", adjust_inhibit_q, 32'h0);
    tl("20250630235958", "+18");
    ck("month", month_q, 32'h06);
    ck("day", day_q, 32'h1E);
    ck("second", second_q, 32'h3A);
    ck("status", time_status_q, 32'h2);
    ck("present", present_leap_count_q, 32'h12);
    ck("future", future_leap_count_q, 32'h13);
    ck("offset", tai_offset_q, 32'h25);
    ck("hold", adjust_inhibit_q, 32'h1);
    tl("20250630235959", "+18");
    tl("20250630235959", "+18");
    ck("rep_sec", second_q, 32'h3B);
    ck("rep_hold", adjust_inhibit_q, 32'h1);
    tl("20250701000000", "+19");
    ck("new_offset", tai_offset_q, 32'h26);
    ck("released", adjust_inhibit_q, 32'h0);
    ck("commits", upd_n, 32'h6);
    $display("leap test done");
  end
  endtask
  // antenna, jamming, refused and disabled sentences
  task t_status;
  begin
    prop(good_maker, 8'h59, ",TPS3,1,2,3,4,5,6,7,8,18", 1'b0);
    ck("antenna", antenna_state_q, 32'h2);
    ck("spoof", spoof_detect_q, 32'h1);
    prop(good_maker, 8'h4A, ",FREQ,GL,5,1,1575,60,1234,99", 1'b0);
    ck("glonass", jam_glonass_q, 32'h1);
    ck("lines", total_output_lines_q, 32'h5);
    ck("freq", first_jammer_frequency_q, 32'h0627);
    ck("peak", first_jammer_peak_q, 32'h3C);
    prop(good_maker, 8'h59, ",TPS3,0,0,0,0,0,0,0,0,0", 1'b1);
    ck("text_sum", cerr_n, 32'h2);
    prop(other_maker, 8'h59, ",TPS3,0,0,0,0,0,0,0,0,0", 1'b0);
    prop(good_maker, 8'h5A, ",TPS3,0,0,0,0,0,0,0,0,0", 1'b0);
    ck("ant_kept", antenna_state_q, 32'h2);
    {dis_tl, dis_ant, dis_jam} = 3'h7;
    prop(good_maker, 8'h59, ",TPS3,0,0,0,0,0,0,0,0,0", 1'b0);
    prop(good_maker, 8'h4A, ",FREQ,GP,5,1,1575,60,1234,99", 1'b0);
    tl("20250801000000", "+19");
    ck("dis_ant", antenna_state_q, 32'h2);
    ck("dis_jam", jam_glonass_q, 32'h1);
    ck("dis_tl", upd_n, 32'h6);
    {dis_tl, dis_ant, dis_jam} = 3'h0;
    $display("status test done");
  end
  endtask
  // standard sentence, other selects
  task t_modes;
    integer p;
  begin
    rx.send_text("GPZDA,120000.00,01,01,2025,00,00", 1'b0);
    ck("standard", nmea_n, 32'h1);
    for (p = 0; p < 8; p = p + 1)
    begin
      if (p != 2 && p != 3)
      begin
        protocol_sel = p[2:0];
        rx.send_report(8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 16'h07E9,
          16'h0012, 1'b0);
        ck("illegal", protocol_illegal_q, {31'h0, p > 3});
        ck("ignored", upd_n, 32'h6);
      end
    end
    $display("mode test done");
  end
  endtask
  // verdict
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // reset, then the scenarios
  initial
  begin
    rst = 1'b1;
    protocol_sel = 3'h2;
    {dis_tl, dis_ant, dis_jam} = 3'h0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    t_binary;
    t_leap;
    t_status;
    t_modes;
    complete_run;
  end
endmodule
